// file: common/fpet_pkg.sv
// Constants, states and register map of the flash program/erase sequencer.
// Assumes a 40 MHz system clock; all waits are counted in its cycles.
//
// How it works
// - Wait at least 10 us after write gate before any setup bit.
// - Wait at least 50 us after program setup before program pulse.
// - Program pulse lasts 150 us on attempts 1-4, 500 us after.
// - Wait at least 10 us after pulse clear before setup clear.
// - Wait at least 10 us after setup clear before program verify.
// - Wait at least 4 us after program verify before dummy write.
// - Wait at least 2 us after the all-ones dummy write before readback.
// - Wait at least 4 us after program verify clear before moving on.
// - At most 403 program attempts per 32-byte unit, then report failure.
// - Wait at least 200 us after erase setup before erase pulse.
// - Each erase pulse lasts 5 ms or 10 ms.
// - Wait at least 10 us after erase pulse clear before setup clear.
// - Wait at least 10 us after erase setup clear before erase verify.
// - Wait 20 us after erase verify, dummy write, then 2 us to readback.
// - Wait at least 5 us after erase verify clear before moving on.
// - Erase retries: 60 with 5 ms pulse, 30 with 10 ms pulse.

package fpet_pkg;

  localparam int CLK_NS = 25;
  localparam int TW = 20;
  localparam int TRYW = 9;

  // Times in their own unit
  localparam int T_GATE_US = 10;
  localparam int T_PSU_US = 50;
  localparam int T_PP_SHORT_US = 150;
  localparam int T_PP_LONG_US = 500;
  localparam int T_P_REC_US = 10;
  localparam int T_PSU_REC_US = 10;
  localparam int T_PV_US = 4;
  localparam int T_DUMMY_US = 2;
  localparam int T_PV_REC_US = 4;
  localparam int T_ESU_US = 200;
  localparam int T_EP_SHORT_MS = 5;
  localparam int T_EP_LONG_MS = 10;
  localparam int T_E_REC_US = 10;
  localparam int T_ESU_REC_US = 10;
  localparam int T_EV_US = 20;
  localparam int T_EV_REC_US = 5;

  // Cycle counts, rounded up except the erase pulse counts, which are truncated
  localparam int GATE_CYC = (T_GATE_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int PSU_CYC = (T_PSU_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int PP_SHORT_CYC = (T_PP_SHORT_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int PP_LONG_CYC = (T_PP_LONG_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int P_REC_CYC = (T_P_REC_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int PSU_REC_CYC = (T_PSU_REC_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int PV_CYC = (T_PV_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int DUMMY_CYC = (T_DUMMY_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int PV_REC_CYC = (T_PV_REC_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int ESU_CYC = (T_ESU_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int EP_SHORT_CYC = (T_EP_SHORT_MS * 1000000) / CLK_NS;
  localparam int EP_LONG_CYC = (T_EP_LONG_MS * 1000000) / CLK_NS;
  localparam int E_REC_CYC = (T_E_REC_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int ESU_REC_CYC = (T_ESU_REC_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int EV_CYC = (T_EV_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int EV_REC_CYC = (T_EV_REC_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_CYC = 3;

  // Attempt limits
  localparam int PROG_MAX_TRY = 403;
  localparam int PROG_SHORT_TRIES = 4;
  localparam int ERASE_TRY_SHORT = 60;
  localparam int ERASE_TRY_LONG = 30;

  // Register map, byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_EXPECT = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam int CTRL_PROG_BIT = 0;
  localparam int CTRL_ERASE_BIT = 1;
  localparam int CTRL_ELONG_BIT = 4;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_FAIL_BIT = 2;
  localparam int ST_TRY_LSB = 16;
  localparam logic [7:0] ERASED_VAL = 8'hFF;

  typedef enum logic [3:0] {
    S_IDLE, S_GATE, S_SETUP, S_PULSE, S_PULSE_OFF, S_SETUP_OFF,
    S_VFY_ON, S_DUMMY, S_READ, S_VFY_OFF
  } fpet_state_e;

endpackage : fpet_pkg

// file: core/fpet_seq.sv
// Flash program/erase sequencer driving the array control pins.
// Assumes software reaches it over APB with zero wait states and that
// the 32 data bytes are already loaded into the array before a start.
`timescale 1ns/1ps
`default_nettype none

module fpet_seq #(
  parameter int ESU_CYC = fpet_pkg::ESU_CYC,
  parameter int PP_SHORT_CYC = fpet_pkg::PP_SHORT_CYC,
  parameter int PP_LONG_CYC = fpet_pkg::PP_LONG_CYC,
  parameter int EP_SHORT_CYC = fpet_pkg::EP_SHORT_CYC,
  parameter int EP_LONG_CYC = fpet_pkg::EP_LONG_CYC,
  parameter int PROG_MAX_TRY = fpet_pkg::PROG_MAX_TRY,
  parameter int ERASE_TRY_SHORT = fpet_pkg::ERASE_TRY_SHORT,
  parameter int ERASE_TRY_LONG = fpet_pkg::ERASE_TRY_LONG
) (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic [7:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic flash_write_gate_out,
  output logic program_setup_out,
  output logic program_pulse_out,
  output logic program_verify_out,
  output logic erase_setup_out,
  output logic erase_pulse_out,
  output logic erase_verify_out,
  output logic dummy_write_out,
  output logic verify_read_out,
  input wire logic [7:0] verify_data_in
);

  localparam int TW = fpet_pkg::TW;
  localparam int TRYW = fpet_pkg::TRYW;

  typedef struct packed {
    fpet_pkg::fpet_state_e st;
    logic erase;
    logic elong;
    logic [7:0] expect_val;
    logic [TRYW-1:0] tries;
    logic done;
    logic fail;
    logic vpass;
    logic gate;
    logic program_setup;
    logic pp;
    logic pv;
    logic erase_setup;
    logic ep;
    logic ev;
    logic dwr;
    logic vrd;
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [31:0] prdata;
    logic [TW-1:0] age;
    logic [TW-1:0] age2;
  } fpet_seq_s;

  fpet_seq_s seq_reg;
  fpet_seq_s seq_next;

  logic tmr_load;
  logic [TW-1:0] tmr_len;
  logic tmr_exp;
  logic apb_wr;
  logic apb_map;
  logic go_prog;
  logic go_erase;
  logic [TRYW-1:0] try_max;
  logic [6:0] ctl_now;

  fpet_wait_timer #(
    .W(TW)
  ) u_timer (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .load_in(tmr_load),
    .len_in(tmr_len),
    .expired_out(tmr_exp)
  );

  assign apb_wr = psel_in && penable_in && pwrite_in;
  assign apb_map = (paddr_in == fpet_pkg::ADDR_CTRL) ||
                   (paddr_in == fpet_pkg::ADDR_EXPECT) ||
                   (paddr_in == fpet_pkg::ADDR_STATUS);
  assign go_prog = apb_wr && (paddr_in == fpet_pkg::ADDR_CTRL) &&
                   pwdata_in[fpet_pkg::CTRL_PROG_BIT];
  assign go_erase = apb_wr && (paddr_in == fpet_pkg::ADDR_CTRL) &&
                    pwdata_in[fpet_pkg::CTRL_ERASE_BIT];
  assign try_max = seq_reg.erase ?
                   (seq_reg.elong ? TRYW'(ERASE_TRY_LONG) :
                    TRYW'(ERASE_TRY_SHORT)) : TRYW'(PROG_MAX_TRY);

  always_comb begin
    seq_next = seq_reg;
    seq_next.dwr = 1'b0;
    seq_next.vrd = 1'b0;
    seq_next.s1 = verify_data_in;
    seq_next.s2 = seq_reg.s1;
    seq_next.s3 = seq_reg.s2;
    // Read data prepared in the setup cycle
    if (psel_in && !penable_in && !pwrite_in) begin
      case (paddr_in)
        fpet_pkg::ADDR_CTRL: begin
          seq_next.prdata = 32'h0;
          seq_next.prdata[fpet_pkg::CTRL_ELONG_BIT] = seq_reg.elong;
        end
        fpet_pkg::ADDR_EXPECT: begin
          seq_next.prdata = {24'h0, seq_reg.expect_val};
        end
        fpet_pkg::ADDR_STATUS: begin
          seq_next.prdata = 32'h0;
          seq_next.prdata[fpet_pkg::ST_BUSY_BIT] =
            (seq_reg.st != fpet_pkg::S_IDLE);
          seq_next.prdata[fpet_pkg::ST_DONE_BIT] = seq_reg.done;
          seq_next.prdata[fpet_pkg::ST_FAIL_BIT] = seq_reg.fail;
          seq_next.prdata[fpet_pkg::ST_TRY_LSB +: TRYW] = seq_reg.tries;
        end
        default: begin
          seq_next.prdata = 32'h0;
        end
      endcase
    end
    // Write one clears done/fail; later FSM set wins
    if (apb_wr && paddr_in == fpet_pkg::ADDR_STATUS) begin
      if (pwdata_in[fpet_pkg::ST_DONE_BIT]) begin
        seq_next.done = 1'b0;
      end
      if (pwdata_in[fpet_pkg::ST_FAIL_BIT]) begin
        seq_next.fail = 1'b0;
      end
    end
    if (seq_reg.st == fpet_pkg::S_IDLE && apb_wr) begin
      if (paddr_in == fpet_pkg::ADDR_EXPECT) begin
        seq_next.expect_val = pwdata_in[7:0];
      end
      if (paddr_in == fpet_pkg::ADDR_CTRL) begin
        seq_next.elong = pwdata_in[fpet_pkg::CTRL_ELONG_BIT];
      end
    end
    case (seq_reg.st)
      fpet_pkg::S_IDLE: begin
        if (go_prog || go_erase) begin
          seq_next.erase = !go_prog;
          seq_next.tries = '0;
          seq_next.done = 1'b0;
          seq_next.fail = 1'b0;
          seq_next.gate = 1'b1;
          seq_next.st = fpet_pkg::S_GATE;
        end
      end
      fpet_pkg::S_GATE: begin
        if (tmr_exp) begin
          seq_next.program_setup = !seq_reg.erase;
          seq_next.erase_setup = seq_reg.erase;
          seq_next.tries = seq_reg.tries + TRYW'(1);
          seq_next.st = fpet_pkg::S_SETUP;
        end
      end
      fpet_pkg::S_SETUP: begin
        if (tmr_exp) begin
          seq_next.pp = !seq_reg.erase;
          seq_next.ep = seq_reg.erase;
          seq_next.st = fpet_pkg::S_PULSE;
        end
      end
      fpet_pkg::S_PULSE: begin
        if (tmr_exp) begin
          seq_next.pp = 1'b0;
          seq_next.ep = 1'b0;
          seq_next.st = fpet_pkg::S_PULSE_OFF;
        end
      end
      fpet_pkg::S_PULSE_OFF: begin
        if (tmr_exp) begin
          seq_next.program_setup = 1'b0;
          seq_next.erase_setup = 1'b0;
          seq_next.st = fpet_pkg::S_SETUP_OFF;
        end
      end
      fpet_pkg::S_SETUP_OFF: begin
        if (tmr_exp) begin
          seq_next.pv = !seq_reg.erase;
          seq_next.ev = seq_reg.erase;
          seq_next.st = fpet_pkg::S_VFY_ON;
        end
      end
      fpet_pkg::S_VFY_ON: begin
        if (tmr_exp) begin
          seq_next.dwr = 1'b1;
          seq_next.st = fpet_pkg::S_DUMMY;
        end
      end
      fpet_pkg::S_DUMMY: begin
        if (tmr_exp) begin
          seq_next.vrd = 1'b1;
          seq_next.st = fpet_pkg::S_READ;
        end
      end
      fpet_pkg::S_READ: begin
        // block verify compare
        // Sample once the synchronised data is stable
        if (tmr_exp && seq_reg.s2 == seq_reg.s3) begin
          seq_next.vpass = seq_reg.erase ?
                           (seq_reg.s3 == fpet_pkg::ERASED_VAL) :
                           (seq_reg.s3 == seq_reg.expect_val);
          seq_next.pv = 1'b0;
          seq_next.ev = 1'b0;
          seq_next.st = fpet_pkg::S_VFY_OFF;
        end
      end
      fpet_pkg::S_VFY_OFF: begin
        if (tmr_exp) begin
          if (seq_reg.vpass) begin
            seq_next.gate = 1'b0;
            seq_next.done = 1'b1;
            seq_next.st = fpet_pkg::S_IDLE;
          end else if (seq_reg.tries >= try_max) begin
            seq_next.gate = 1'b0;
            seq_next.fail = 1'b1;
            seq_next.st = fpet_pkg::S_IDLE;
          end else begin
            seq_next.program_setup = !seq_reg.erase;
            seq_next.erase_setup = seq_reg.erase;
            seq_next.tries = seq_reg.tries + TRYW'(1);
            seq_next.st = fpet_pkg::S_SETUP;
          end
        end
      end
      default: begin
        seq_next.st = fpet_pkg::S_IDLE;
      end
    endcase
    // Cycles since last level change of the control pins
    if ({seq_next.gate, seq_next.program_setup, seq_next.pp, seq_next.pv,
         seq_next.erase_setup, seq_next.ep, seq_next.ev} != ctl_now) begin
      seq_next.age = TW'(1);
    end else if (seq_reg.age != '1) begin
      seq_next.age = seq_reg.age + TW'(1);
    end
    if (seq_next.dwr) begin
      seq_next.age2 = TW'(1);
    end else if (seq_reg.age2 != '1) begin
      seq_next.age2 = seq_reg.age2 + TW'(1);
    end
  end

  assign ctl_now = {seq_reg.gate, seq_reg.program_setup, seq_reg.pp, seq_reg.pv,
                    seq_reg.erase_setup, seq_reg.ep, seq_reg.ev};

  always_comb begin
    tmr_load = (seq_next.st != seq_reg.st);
    case (seq_next.st)
      fpet_pkg::S_GATE: tmr_len = TW'(fpet_pkg::GATE_CYC);
      fpet_pkg::S_SETUP: begin
        tmr_len = seq_next.erase ? TW'(ESU_CYC) : TW'(fpet_pkg::PSU_CYC);
      end
      fpet_pkg::S_PULSE: begin
        if (seq_next.erase) begin
          tmr_len = seq_next.elong ? TW'(EP_LONG_CYC) : TW'(EP_SHORT_CYC);
        end else if (seq_next.tries <= TRYW'(fpet_pkg::PROG_SHORT_TRIES)) begin
          tmr_len = TW'(PP_SHORT_CYC);
        end else begin
          tmr_len = TW'(PP_LONG_CYC);
        end
      end
      fpet_pkg::S_PULSE_OFF: begin
        tmr_len = seq_next.erase ? TW'(fpet_pkg::E_REC_CYC) :
                  TW'(fpet_pkg::P_REC_CYC);
      end
      fpet_pkg::S_SETUP_OFF: begin
        tmr_len = seq_next.erase ? TW'(fpet_pkg::ESU_REC_CYC) :
                  TW'(fpet_pkg::PSU_REC_CYC);
      end
      fpet_pkg::S_VFY_ON: begin
        tmr_len = seq_next.erase ? TW'(fpet_pkg::EV_CYC) :
                  TW'(fpet_pkg::PV_CYC);
      end
      fpet_pkg::S_DUMMY: tmr_len = TW'(fpet_pkg::DUMMY_CYC);
      fpet_pkg::S_READ: tmr_len = TW'(fpet_pkg::SYNC_CYC);
      fpet_pkg::S_VFY_OFF: begin
        tmr_len = seq_next.erase ? TW'(fpet_pkg::EV_REC_CYC) :
                  TW'(fpet_pkg::PV_REC_CYC);
      end
      default: tmr_len = TW'(1);
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      seq_reg <= '0;
    end else begin
      seq_reg <= seq_next;
    end
  end

  assign prdata_out = seq_reg.prdata;
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && !apb_map;
  assign flash_write_gate_out = seq_reg.gate;
  assign program_setup_out = seq_reg.program_setup;
  assign program_pulse_out = seq_reg.pp;
  assign program_verify_out = seq_reg.pv;
  assign erase_setup_out = seq_reg.erase_setup;
  assign erase_pulse_out = seq_reg.ep;
  assign erase_verify_out = seq_reg.ev;
  assign dummy_write_out = seq_reg.dwr;
  assign verify_read_out = seq_reg.vrd;

  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);

  AST_GATE_WAIT: assert property (
    $rose(program_setup_out || erase_setup_out) && seq_reg.tries == 1 |->
      $past(seq_reg.age) >= fpet_pkg::GATE_CYC)
    else $error("setup bit set too soon after gate");
  AST_PSU_WAIT: assert property (
    $rose(program_pulse_out) |-> $past(seq_reg.age) >= fpet_pkg::PSU_CYC)
    else $error("program pulse too soon after setup");
  AST_PP_WIDTH: assert property (
    $fell(program_pulse_out) |-> $past(seq_reg.age) ==
      ((seq_reg.tries <= fpet_pkg::PROG_SHORT_TRIES) ?
       PP_SHORT_CYC : PP_LONG_CYC))
    else $error("program pulse width wrong for attempt");
  AST_P_REC: assert property (
    $fell(program_setup_out) |-> $past(seq_reg.age) >= fpet_pkg::P_REC_CYC)
    else $error("setup cleared too soon after pulse");
  AST_PV_ON: assert property (
    $rose(program_verify_out) |->
      $past(seq_reg.age) >= fpet_pkg::PSU_REC_CYC)
    else $error("verify set too soon after setup clear");
  AST_DUMMY_WAIT: assert property (
    dummy_write_out |-> (program_verify_out || erase_verify_out) &&
      seq_reg.age >= (erase_verify_out ? fpet_pkg::EV_CYC :
                      fpet_pkg::PV_CYC))
    else $error("dummy write too soon after verify set");
  AST_READ_WAIT: assert property (
    verify_read_out |-> $past(seq_reg.age2) == fpet_pkg::DUMMY_CYC)
    else $error("readback not spaced from dummy write");
  AST_TRY_CAP: assert property (
    $rose(program_setup_out || erase_setup_out) |->
      seq_reg.tries <= try_max && seq_reg.tries != 0)
    else $error("attempt count beyond limit");
  AST_ESU_WAIT: assert property (
    $rose(erase_pulse_out) |-> $past(seq_reg.age) >= ESU_CYC)
    else $error("erase pulse too soon after setup");
  AST_EP_WIDTH: assert property (
    $fell(erase_pulse_out) |-> $past(seq_reg.age) ==
      (seq_reg.elong ? EP_LONG_CYC : EP_SHORT_CYC))
    else $error("erase pulse width wrong");
  AST_GATE_LAST: assert property (
    $fell(flash_write_gate_out) |-> ctl_now == '0 &&
      $past(seq_reg.age) >= (seq_reg.erase ? fpet_pkg::EV_REC_CYC :
                             fpet_pkg::PV_REC_CYC))
    else $error("gate dropped early or bits left set");

  COV_PROG_DONE: cover property (
    $fell(flash_write_gate_out) && !seq_reg.erase && seq_reg.done);
  COV_ERASE_DONE: cover property (
    $fell(flash_write_gate_out) && seq_reg.erase && seq_reg.done);
  COV_RETRY: cover property (
    $rose(program_setup_out) && seq_reg.tries == 2);
  COV_FAIL: cover property ($rose(seq_reg.fail));

endmodule : fpet_seq
`default_nettype wire

// file: core/fpet_wait_timer.sv
// Down counter for sequencer waits: expired goes high len cycles after load.
// Assumes len is at least one and is held only in the load cycle.
`timescale 1ns/1ps
`default_nettype none

module fpet_wait_timer #(
  parameter int W = 20
) (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic load_in,
  input wire logic [W-1:0] len_in,
  output logic expired_out
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } fpet_tmr_s;

  fpet_tmr_s tmr_reg;
  fpet_tmr_s tmr_next;

  always_comb begin
    tmr_next = tmr_reg;
    if (load_in) begin
      tmr_next.cnt = len_in - W'(1);
    end else if (tmr_reg.cnt != '0) begin
      tmr_next.cnt = tmr_reg.cnt - W'(1);
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tmr_reg <= '0;
    end else begin
      tmr_reg <= tmr_next;
    end
  end

  assign expired_out = (tmr_reg.cnt == '0);

endmodule : fpet_wait_timer
`default_nettype wire

// file: testbench/flash_program_erase_timing_tb_top.sv
// Self-checking bench of the program/erase sequencer with an array model.
// Assumes shortened pulse, erase setup and retry parameters; other waits stay real.
`timescale 1ns/1ps
`default_nettype none

module flash_program_erase_timing_tb_top;
  typedef struct {
    logic [31:0] ctrl;
    logic [7:0] exp;
    logic [8:0] good;
    logic [2:0] st;
    logic [8:0] tries;
  } fpet_row_s;
  fpet_row_s rows [7] = '{
    '{32'h1, 8'hA5, 9'h1, 3'h2, 9'h1}, '{32'h1, 8'h3C, 9'h5, 3'h2, 9'h5},
    '{32'h1, 8'h00, 9'h63, 3'h4, 9'h6}, '{32'h3, 8'h81, 9'h1, 3'h2, 9'h1},
    '{32'h2, 8'hFF, 9'h2, 3'h2, 9'h2}, '{32'h2, 8'hFF, 9'h63, 3'h4, 9'h3},
    '{32'h12, 8'hFF, 9'h63, 3'h4, 9'h2}};
  logic clk = 1'h0, rstn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00, vdata, good_byte = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat, cur_ctrl = 32'h0;
  logic pready, pslverr, serr, gate, program_setup, pp, pv, erase_setup, ep, ev, dw, rd;
  logic [8:0] good_after = 9'h0;
  logic [6:0] lv, lv_q = 7'h0, r, f;
  logic dw_q = 1'h0, rd_q = 1'h0;
  int fail_count = 0, tests_run = 0, gap = 0, np = 0, ne = 0;

  always #12.5 clk = ~clk;

  fpet_seq #(.ESU_CYC(20), .PP_SHORT_CYC(30), .PP_LONG_CYC(40),
    .EP_SHORT_CYC(60), .EP_LONG_CYC(80), .PROG_MAX_TRY(6),
    .ERASE_TRY_SHORT(3), .ERASE_TRY_LONG(2)) u_dut (.ref_clk_in(clk),
    .rstn_in(rstn), .paddr_in(paddr), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .flash_write_gate_out(gate), .program_setup_out(program_setup),
    .program_pulse_out(pp), .program_verify_out(pv),
    .erase_setup_out(erase_setup), .erase_pulse_out(ep), .erase_verify_out(ev),
    .dummy_write_out(dw), .verify_read_out(rd), .verify_data_in(vdata));

  fpet_flash_model u_flash (.ref_clk_in(clk), .rstn_in(rstn),
    .flash_write_gate_in(gate), .program_pulse_in(pp),
    .erase_pulse_in(ep), .erase_verify_in(ev), .verify_read_in(rd),
    .good_after_in(good_after), .good_byte_in(good_byte),
    .verify_data_out(vdata));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic chkge(input int g, input int m);
    check(g >= m ? m : g, m);
  endtask : chkge

  task conclude;
    $display("Counts: %0d compared, %0d mismatched", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (n >= 50) begin
      fail_count++;
      conclude();
    end
    rdat = prdata;
    serr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic run(input fpet_row_s t, input logic inject);
    int k;
    cur_ctrl = t.ctrl;
    good_after <= t.good;
    good_byte <= t.exp;
    apb(1'h1, fpet_pkg::ADDR_EXPECT, {24'h0, t.exp});
    apb(1'h1, fpet_pkg::ADDR_CTRL, t.ctrl);
    if (inject) apb(1'h1, fpet_pkg::ADDR_CTRL, 32'h2);
    for (k = 0; k < 20000; k++) begin
      apb(1'h0, fpet_pkg::ADDR_STATUS, 32'h0);
      if (rdat[0] === 1'h0) break;
    end
    if (k >= 20000) begin
      fail_count++;
      conclude();
    end
    check({29'h0, rdat[2:0]}, {29'h0, t.st});
    check({23'h0, rdat[24:16]}, {23'h0, t.tries});
    check(t.ctrl[0] ? np : ne, {23'h0, t.tries});
    check(t.ctrl[0] ? ne : np, 32'h0);
    apb(1'h1, fpet_pkg::ADDR_STATUS, 32'h6);
    apb(1'h0, fpet_pkg::ADDR_STATUS, 32'h0);
    check({29'h0, rdat[2:0]}, 32'h0);
  endtask : run

  // Edge timing monitor on the array control pins
  assign lv = {gate, program_setup, pp, pv, erase_setup, ep, ev};
  always @(posedge clk) begin
    r = lv & ~lv_q;
    f = ~lv & lv_q;
    gap <= gap + 1;
    if (rstn && (lv !== lv_q || (dw && !dw_q) || (rd && !rd_q))) begin
      gap <= 1;
      np <= r[6] ? 0 : np + int'(r[4]);
      ne <= r[6] ? 0 : ne + int'(r[1]);
      if (r[5]) chkge(gap, np == 0 ? fpet_pkg::GATE_CYC : fpet_pkg::PV_REC_CYC);
      if (r[2]) chkge(gap, ne == 0 ? fpet_pkg::GATE_CYC : fpet_pkg::EV_REC_CYC);
      if (r[4]) chkge(gap, fpet_pkg::PSU_CYC);
      if (f[4]) check(gap, np <= 4 ? 30 : 40);
      if (f[5]) chkge(gap, fpet_pkg::P_REC_CYC);
      if (r[3]) chkge(gap, fpet_pkg::PSU_REC_CYC);
      if (dw && !dw_q) chkge(gap, lv_q[3] ? fpet_pkg::PV_CYC : fpet_pkg::EV_CYC);
      if (rd && !rd_q) chkge(gap, fpet_pkg::DUMMY_CYC);
      if (r[1]) chkge(gap, 20);
      if (f[1]) check(gap, cur_ctrl[4] ? 80 : 60);
      if (f[2]) chkge(gap, fpet_pkg::E_REC_CYC);
      if (r[0]) chkge(gap, fpet_pkg::ESU_REC_CYC);
      if (f[6]) check({26'h0, lv[5:0]}, 32'h0);
      if (f[6]) chkge(gap, cur_ctrl[0] ? fpet_pkg::PV_REC_CYC : fpet_pkg::EV_REC_CYC);
    end
    lv_q <= rstn ? lv : 7'h0;
    dw_q <= dw;
    rd_q <= rd;
  end

  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'h1;
    foreach (rows[i]) begin
      run(rows[i], 1'h0);
      $display("Row %0d finished", i);
    end
    run('{32'h1, 8'h96, 9'h1, 3'h2, 9'h1}, 1'h1);
    $display("Start while busy finished");
    apb(1'h0, 8'h0C, 32'h0);
    check({31'h0, serr}, 32'h1);
    check(rdat, 32'h0);
    apb(1'h1, 8'h0C, 32'h1);
    check({31'h0, serr}, 32'h1);
    apb(1'h1, fpet_pkg::ADDR_CTRL, 32'h10);
    apb(1'h0, fpet_pkg::ADDR_CTRL, 32'h0);
    check(rdat & 32'h10, 32'h10);
    $display("Register access finished");
    cur_ctrl = 32'h2;
    apb(1'h1, fpet_pkg::ADDR_CTRL, 32'h2);
    repeat (600) @(posedge clk);
    rstn <= 1'h0;
    @(posedge clk);
    check({25'h0, lv}, 32'h0);
    rstn <= 1'h1;
    apb(1'h0, fpet_pkg::ADDR_STATUS, 32'h0);
    check(rdat, 32'h0);
    apb(1'h0, fpet_pkg::ADDR_CTRL, 32'h0);
    check(rdat & 32'h10, 32'h0);
    $display("Reset in mid-run finished");
    conclude();
  end

  initial begin
    repeat (99000) @(posedge clk);
    fail_count++;
    conclude();
  end
endmodule : flash_program_erase_timing_tb_top

`default_nettype wire

// file: testbench/fpet_flash_model.sv
// Behavioural flash array answering the sequencer's verify readback.
// Assumes the bench sets good_after_in and good_byte_in before each start.
`timescale 1ns/1ps
`default_nettype none

module fpet_flash_model (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic flash_write_gate_in,
  input wire logic program_pulse_in,
  input wire logic erase_pulse_in,
  input wire logic erase_verify_in,
  input wire logic verify_read_in,
  input wire logic [8:0] good_after_in,
  input wire logic [7:0] good_byte_in,
  output logic [7:0] verify_data_out
);
  logic [8:0] pulses;
  logic [3:0] hold;
  logic pulse_q;

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pulses <= 9'h000;
      hold <= 4'h0;
      pulse_q <= 1'h0;
      verify_data_out <= 8'h00;
    end else begin
      pulse_q <= program_pulse_in | erase_pulse_in;
      if (!flash_write_gate_in) begin
        pulses <= 9'h000;
      end else if ((program_pulse_in | erase_pulse_in) && !pulse_q) begin
        pulses <= pulses + 9'h001;
      end
      if (verify_read_in) begin
        hold <= 4'h8;
        if (pulses >= good_after_in) begin
          verify_data_out <= erase_verify_in ? 8'hFF : good_byte_in;
        end else begin
          verify_data_out <= good_byte_in ^ 8'h5A;
        end
      end else if (hold != 4'h0) begin
        hold <= hold - 4'h1;
      end else begin
        // Released line keeps changing
        verify_data_out <= ~verify_data_out;
      end
    end
  end
endmodule : fpet_flash_model

`default_nettype wire
